// File: tws_pkg.sv
// Shared constants and types for the two-wire slave receiver.
// Assumes a 32-bit AXI4-Lite register bus and an open-drain bus pair.
package tws_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;                       // Byte address width.
   localparam logic [3:0] OFS_CONTROL = 4'h0;       // serial_control_reg.
   localparam logic [3:0] OFS_STATUS = 4'h4;        // serial_status_reg.
   localparam logic [3:0] OFS_DATA = 4'h8;          // serial_data_reg.
   localparam logic [3:0] OFS_OWN_ADDR = 4'hC;      // own_address_reg.

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTL_FLAG = 7;                     // service_flag.
   localparam int CTL_ACK_EN = 6;                   // ack_enable.
   localparam int CTL_START = 5;                    // start_request.
   localparam int CTL_STOP = 4;                     // stop_request.
   localparam int CTL_WCOL = 3;                     // write_collision_flag.
   localparam int CTL_IF_EN = 2;                    // interface_enable.
   localparam int CTL_IRQ_EN = 0;                   // irq_enable.

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_OWN_ADDR = 8'h00;     // No address, no call.
   localparam logic [7:0] RST_DATA = 8'hFF;         // Data register.
   localparam logic [7:0] RST_STATUS = 8'hF8;       // No relevant state.

   // ----------------------------------------------------------------
   // Status codes, prescaler bits zero
   // ----------------------------------------------------------------
   localparam logic [7:0] ST_OWN_W = 8'h60;         // Own address, write.
   localparam logic [7:0] ST_ARB_OWN_W = 8'h68;     // Same after lost arb.
   localparam logic [7:0] ST_GCALL = 8'h70;         // General call.
   localparam logic [7:0] ST_ARB_GCALL = 8'h78;     // Same after lost arb.
   localparam logic [7:0] ST_DATA_ACK = 8'h80;      // Own data, acked.
   localparam logic [7:0] ST_DATA_NACK = 8'h88;     // Own data, not acked.
   localparam logic [7:0] ST_GDATA_ACK = 8'h90;     // Call data, acked.
   localparam logic [7:0] ST_GDATA_NACK = 8'h98;    // Call data, not acked.
   localparam logic [7:0] GCALL_ADDR = 8'h00;       // general_call_addr.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;     // Bits before the ack.
   localparam logic [1:0] RESP_OKAY = 2'h0;         // AXI okay answer.
   localparam logic [1:0] RESP_SLVERR = 2'h2;       // AXI slave error.

   // Bus-side states of the receiver.
   typedef enum logic [2:0] {
      S_IDLE,    // Waiting for a start condition.
      S_ADDR,    // Shifting the address byte.
      S_AACK,    // Driving the address acknowledge.
      S_DATA,    // Shifting a data byte.
      S_DACK,    // Driving or withholding the data acknowledge.
      S_SVC,     // Clock held low until software services.
      S_SKIP     // Not addressed; ignore until the next start.
   } tws_state_t;

endpackage

// File: tws_sync.sv
// Two-flop synchroniser for one bus line.
// Assumes the line idles high, so reset loads ones.
`timescale 1ns/100ps
module tws_sync (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Asynchronous line in, synchronised level out.
   input wire logic d,
   output logic q
);

   // ----------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------
   logic meta_q; // First stage, read only by the second.

   // Both stages reset to the idle level of the line.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b1;
         q <= 1'b1;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// File: tws_slave_rx.sv
// Two-wire slave receiver with an AXI4-Lite register file.
// Assumes open-drain scl and sda resolved outside, one clock.
// Operation
// - Match upper seven own-address bits only
// - Low own-address bit enables general call
// - Direction bit zero selects receiving
// - Address with write sets flag, status
// - Lost arbitration then addressed gives 0x68/0x78
// - Cleared ack enable gives not-acknowledge next
// - Ack disabled: ignore address, keep monitoring
// - Sleeping, address match still wakes part
// - Hold clock low until flag cleared
// - Data register not updated while asleep
// - Own address acked reports 0x60
// - Lost arbitration, own address reports 0x68
// - General call acked reports 0x70
// - Lost arbitration, general call reports 0x78
// - Acked own data reports 0x80
// - Not-acked own data reports 0x88, then unaddressed
// - Start request then start when free; owed only when not-acked data ends addressed mode
// - Codes assume prescaler bits zero
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module tws_slave_rx
   import tws_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [tws_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [tws_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Open-drain bus lines.
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Master-side and power-side hooks.
   input wire logic arb_lost,
   input wire logic sleep_deep,
   output logic wake_req,
   output logic start_issue
);
   import tws_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      tws_state_t st;       // Bus-side state.
      logic scl_p;          // Previous synchronised clock.
      logic sda_p;          // Previous synchronised data.
      logic [3:0] bitc;     // Bits shifted in this byte.
      logic [7:0] sh;       // Receive shift register.
      logic ack_q;          // Acknowledge the byte in flight.
      logic gc_q;           // Addressed by general call.
      logic arb_q;          // Arbitration was lost as master.
      logic drop_q;         // Leave addressed mode after service.
      logic sda_oe;         // Driving data low.
      logic scl_oe;         // Holding clock low.
      logic flag;           // service_flag.
      logic ack_en;         // ack_enable.
      logic start_req;      // start_request.
      logic stop_req;       // stop_request.
      logic wcol;           // write_collision_flag.
      logic if_en;          // interface_enable.
      logic irq_en;         // irq_enable.
      logic [7:0] status;   // Status code, low bits zero.
      logic [1:0] presc;    // Prescaler bits.
      logic [7:0] data;     // serial_data_reg.
      logic [7:0] own;      // own_address_reg.
      logic start_pend;     // Start owed once bus is free.
      logic start_issue;    // Start handed to the master side.
      logic wake;           // Wake pulse.
      logic aw_got;         // Write address held.
      logic [ADDR_W-1:0] awa; // Held write address.
      logic w_got;          // Write data held.
      logic [7:0] wd;       // Held write data byte.
      logic wen;            // Byte lane 0 strobe.
      logic bvalid;         // Write answer pending.
      logic [1:0] bresp;    // Write answer code.
      logic rvalid;         // Read answer pending.
      logic [7:0] rdata;    // Read answer data.
      logic [1:0] rresp;    // Read answer code.
   } tws_regs_t;

   tws_regs_t q, d;         // Registered state and its next value.
   logic scl_s, sda_s;      // Synchronised bus lines.
   logic scl_r, scl_f;      // Clock edges.
   logic start_c, stop_c;   // Bus conditions.
   logic own_hit, gc_hit;   // Address byte decode.

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   tws_sync u_scl (.aclk(aclk), .aresetn(aresetn), .d(scl_i), .q(scl_s));
   tws_sync u_sda (.aclk(aclk), .aresetn(aresetn), .d(sda_i), .q(sda_s));

   // Edges and conditions seen on the synchronised lines.
   assign scl_r = scl_s && !q.scl_p;
   assign scl_f = !scl_s && q.scl_p;
   assign start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
   assign stop_c = scl_s && q.scl_p && !q.sda_p && sda_s;
   // Upper seven bits with write direction, or the enabled call.
   assign own_hit = (q.sh[7:1] == q.own[7:1]) && !q.sh[0];
   assign gc_hit = (q.sh == GCALL_ADDR) && q.own[0];

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Software accesses first, bus events after, so hardware sets win.
   always_comb begin
      d = q;
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      d.start_issue = 1'b0;
      d.wake = 1'b0;
      if (arb_lost) begin
         d.arb_q = 1'b1;
      end
      // Write address and data are taken in either order.
      if (awvalid && !q.aw_got && !q.bvalid) begin
         d.aw_got = 1'b1;
         d.awa = awaddr;
      end
      if (wvalid && !q.w_got && !q.bvalid) begin
         d.w_got = 1'b1;
         d.wd = wdata[7:0];
         d.wen = wstrb[0];
      end
      // Both halves held: perform the write and answer.
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         if (q.awa == OFS_CONTROL) begin
            if (q.wen) begin
               // Writing one clears the flag.
               if (q.wd[CTL_FLAG]) begin
                  d.flag = 1'b0;
               end
               d.ack_en = q.wd[CTL_ACK_EN];
               d.start_req = q.wd[CTL_START];
               d.stop_req = q.wd[CTL_STOP];
               d.if_en = q.wd[CTL_IF_EN];
               d.irq_en = q.wd[CTL_IRQ_EN];
            end
         end else if (q.awa == OFS_STATUS) begin
            // Only the prescaler bits are writable.
            if (q.wen) begin
               d.presc = q.wd[1:0];
            end
         end else if (q.awa == OFS_DATA) begin
            // Data may change only while the flag is set.
            if (q.wen && q.flag) begin
               d.data = q.wd;
               d.wcol = 1'b0;
            end else if (q.wen) begin
               d.wcol = 1'b1;
            end
         end else if (q.awa == OFS_OWN_ADDR) begin
            if (q.wen) begin
               d.own = q.wd;
            end
         end else begin
            d.bresp = RESP_SLVERR;
         end
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      // Read answer is registered one cycle after address acceptance.
      if (arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         if (araddr == OFS_CONTROL) begin
            d.rdata = {q.flag, q.ack_en, q.start_req, q.stop_req,
                       q.wcol, q.if_en, 1'b0, q.irq_en};
         end else if (araddr == OFS_STATUS) begin
            d.rdata = q.status | {6'h00, q.presc};
         end else if (araddr == OFS_DATA) begin
            d.rdata = q.data;
         end else if (araddr == OFS_OWN_ADDR) begin
            d.rdata = q.own;
         end else begin
            d.rdata = 8'h00;
            d.rresp = RESP_SLVERR;
         end
      end else if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      // Bus side: disabled, start, stop, then per-state work.
      if (!q.if_en) begin
         d.st = S_IDLE;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
      end else if (start_c && q.st != S_SVC) begin
         d.st = S_ADDR;
         d.bitc = 4'h0;
         d.sda_oe = 1'b0;
      end else if (stop_c) begin
         d.st = S_IDLE;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
         d.arb_q = 1'b0;
         // The bus is free now: hand the owed start over.
         if (q.start_pend) begin
            d.start_pend = 1'b0;
            d.start_issue = 1'b1;
            d.start_req = 1'b0;
         end
      end else begin
         case (q.st)
            S_ADDR: begin
               if (scl_r) begin
                  d.sh = {q.sh[6:0], sda_s};
                  d.bitc = q.bitc + 4'h1;
               end else if (scl_f && q.bitc == BITS_PER_BYTE) begin
                  // Ack only with ack enabled; otherwise keep watching.
                  if (q.ack_en && (own_hit || gc_hit)) begin
                     d.sda_oe = 1'b1;
                     d.gc_q = gc_hit;
                     d.st = S_AACK;
                     d.wake = sleep_deep;
                  end else begin
                     d.st = S_SKIP;
                  end
               end
            end
            S_AACK: begin
               // End of the ack bit: report and stretch.
               if (scl_f) begin
                  d.sda_oe = 1'b0;
                  d.scl_oe = 1'b1;
                  d.flag = 1'b1;
                  d.drop_q = 1'b0;
                  d.arb_q = 1'b0;
                  d.st = S_SVC;
                  if (q.gc_q) begin
                     d.status = q.arb_q ? ST_ARB_GCALL : ST_GCALL;
                  end else begin
                     d.status = q.arb_q ? ST_ARB_OWN_W : ST_OWN_W;
                  end
               end
            end
            S_DATA: begin
               if (scl_r) begin
                  d.sh = {q.sh[6:0], sda_s};
                  d.bitc = q.bitc + 4'h1;
               end else if (scl_f && q.bitc == BITS_PER_BYTE) begin
                  // Released line means not-acknowledge.
                  d.sda_oe = q.ack_q;
                  d.st = S_DACK;
               end
            end
            S_DACK: begin
               if (scl_f) begin
                  d.sda_oe = 1'b0;
                  d.scl_oe = 1'b1;
                  d.flag = 1'b1;
                  d.drop_q = !q.ack_q;
                  d.st = S_SVC;
                  // Asleep the core clock is off: data is not captured.
                  if (!sleep_deep) begin
                     d.data = q.sh;
                  end
                  if (q.ack_q) begin
                     d.status = q.gc_q ? ST_GDATA_ACK : ST_DATA_ACK;
                  end else begin
                     d.status = q.gc_q ? ST_GDATA_NACK : ST_DATA_NACK;
                  end
               end
            end
            S_SVC: begin
               // Release the clock only once software clears the flag.
               if (!q.flag) begin
                  d.scl_oe = 1'b0;
                  d.bitc = 4'h0;
                  d.ack_q = q.ack_en;
                  if (q.drop_q) begin
                     d.st = S_SKIP;
                     d.start_pend = q.start_req;
                  end else begin
                     d.st = S_DATA;
                  end
               end
            end
            default: begin
               // Idle and skip wait for the next start.
               d.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.st <= S_IDLE;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
         q.status <= RST_STATUS;
         q.data <= RST_DATA;
         q.own <= RST_OWN_ADDR;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign awready = !q.aw_got && !q.bvalid;
   assign wready = !q.w_got && !q.bvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = !q.rvalid;
   assign rvalid = q.rvalid;
   assign rresp = q.rresp;
   assign rdata = {24'h000000, q.rdata};
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = q.scl_oe;
   assign sda_oe = q.sda_oe;
   assign wake_req = q.wake;
   assign start_issue = q.start_issue;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // The clock is held for as long as service is owed.
   a_stretch_held:
   assert property (q.st == S_SVC && q.flag |-> scl_oe)
      else $error("clock not held while flag set");
   // The clock is freed within two cycles of the flag clearing.
   a_stretch_release:
   assert property ($fell(q.flag) && q.st == S_SVC |-> ##[1:2] !scl_oe)
      else $error("clock not released after flag clear");
   // Every raised flag carries a receiver status code.
   a_flag_status:
   assert property ($rose(q.flag) |-> q.status[2:0] == 3'h0
                    && q.status >= ST_OWN_W && q.status <= ST_GDATA_NACK)
      else $error("flag raised without a valid code");
   // Own-address codes follow a true seven-bit match with write.
   a_own_match:
   assert property ($rose(q.flag) && (q.status == ST_OWN_W
                    || q.status == ST_ARB_OWN_W)
                    |-> q.sh[7:1] == q.own[7:1] && !q.sh[0])
      else $error("own code without address match");
   // General call is only answered when enabled.
   a_gcall_enable:
   assert property ($rose(q.flag) && q.status == ST_GCALL |-> q.own[0]
                    && q.sh == GCALL_ADDR)
      else $error("general call answered while disabled");
   // No address acknowledge while ack is disabled.
   a_addr_ack_gate:
   assert property (q.st == S_ADDR ##1 q.st == S_AACK |-> $past(q.ack_en))
      else $error("address acked with ack disabled");
   // A byte taken without ack enabled leaves the line released.
   a_nack_drive:
   assert property (q.st == S_DACK && !q.ack_q |-> !sda_oe)
      else $error("data acked with ack disabled");
   // Not-acked data is reported with its own code.
   a_nack_code:
   assert property ($rose(q.flag) && $past(q.st) == S_DACK && !q.ack_q
                    && !q.gc_q |-> q.status == ST_DATA_NACK)
      else $error("not-acked data misreported");
   // A wake pulse comes only from a sleeping match with ack enabled.
   a_wake_cause:
   assert property (wake_req |-> $past(sleep_deep) && $past(q.ack_en))
      else $error("wake without sleeping match");
   // An owed start is issued only at a stop.
   a_start_free:
   assert property (start_issue |-> $past(stop_c) && $past(q.start_pend))
      else $error("start issued while bus busy");

endmodule

// File: tws_bus_master.sv
// Behavioural two-wire bus master transmitter that faces the slave receiver.
// Assumes both lines are pulled up and resolved by the bench from all enables.
`timescale 1ns/100ps
module tws_bus_master (
   // Clock.
   input wire logic aclk,
   // Resolved bus lines.
   input wire logic scl,
   input wire logic sda,
   // Pull-down enables, high while this model pulls a line low.
   output logic scl_oe,
   output logic sda_oe
);
   // ---------------------------------------------------------------
   // Bus phases
   // ---------------------------------------------------------------
   // Both lines are released while no frame is under way.
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // One line phase, well above the slave's sampling delay.
   task automatic hold();
      repeat (10) @(posedge aclk);
   endtask
   // Releases the clock, then waits while the slave stretches it.
   task automatic rise();
      scl_oe <= 1'b0;
      hold();
      while (scl !== 1'b1) @(posedge aclk);
   endtask
   // Start: data falls while the clock is high.
   task automatic start();
      sda_oe <= 1'b0;
      rise();
      sda_oe <= 1'b1;
      hold();
      scl_oe <= 1'b1;
      hold();
   endtask
   // Sends a byte, top bit first, and samples the acknowledge slot.
   task automatic xfer(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_oe <= !b[i];
         hold();
         rise();
         hold();
         scl_oe <= 1'b1;
         hold();
      end
      sda_oe <= 1'b0;
      rise();
      ack = (sda === 1'b0);
      hold();
      scl_oe <= 1'b1;
      hold();
   endtask
   // Stop: data rises while the clock is high, then the bus is free.
   task automatic stop();
      sda_oe <= 1'b1;
      hold();
      rise();
      hold();
      sda_oe <= 1'b0;
      hold();
   endtask
endmodule

// File: test_tws_slave_rx.sv
// Self-checking bench for the two-wire slave receiver.
// Assumes the bus master model and AXI4-Lite access by local tasks.
`timescale 1ns/100ps
module test_tws_slave_rx;
   import tws_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, scl_o, sda_o, wake_req, start_issue;
   logic [1:0] bresp, rresp;
   logic scl_oe, sda_oe, m_scl, m_sda;
   logic arb_lost = 1'b0, sleep_deep = 1'b0;
   wire scl = !(scl_oe | m_scl);
   wire sda = !(sda_oe | m_sda);
   int n_fail = 0, comparisons = 0, cyc = 0, n_start = 0, n_wake = 0;
   always #2.5 aclk = ~aclk;
   tws_slave_rx tws_slave_rx_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_deep(sleep_deep),
      .wake_req(wake_req), .start_issue(start_issue));
   tws_bus_master tws_bus_master_inst (.aclk(aclk), .scl(scl), .sda(sda), .scl_oe(m_scl),
      .sda_oe(m_sda));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Register write; each ready and the answer are taken at the rising edge that moves them.
   task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         r = bresp;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   // Register read returning the low byte, taken at the edge that sees rvalid.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         d = rdata[7:0];
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   // Reads the status code with the prescaler bits masked off.
   task automatic st(input logic [7:0] e);
      logic [7:0] d;
      rd(OFS_STATUS, d);
      chk("status", d & 8'hF8, e);
   endtask
   // Start condition followed by an address byte.
   task automatic adr(input logic [7:0] b, output logic a);
      tws_bus_master_inst.start();
      tws_bus_master_inst.xfer(b, a);
   endtask
   // Cycle counter for the hang limit, and pulse counters.
   always @(posedge aclk) begin
      cyc++;
      if (start_issue === 1'b1) n_start++;
      if (wake_req === 1'b1) n_wake++;
      if (cyc == 40000) begin
         n_fail++;
         give_verdict();
      end
   end
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [1:0] r;
      logic a;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CONTROL, d);
      chk("control", d, 8'h00);
      rd(OFS_STATUS, d);
      chk("status", d, RST_STATUS);
      rd(OFS_DATA, d);
      chk("data", d, RST_DATA);
      wr(4'h2, 8'h00, r);
      chk("bresp", {6'h0, r}, {6'h0, RESP_SLVERR});
      rd(4'h2, d);
      chk("unmapped", d, 8'h00);
      chk("rresp", {6'h0, rresp}, {6'h0, RESP_SLVERR});
      // Nonzero prescaler bits make the status mask matter.
      wr(OFS_STATUS, 8'h03, r);
      $display("test reset done");
      wr(OFS_OWN_ADDR, 8'hB5, r);
      wr(OFS_CONTROL, 8'h44, r);
      adr(8'h66, a);
      chk("foreign ack", {7'h0, a}, 8'h00);
      tws_bus_master_inst.stop();
      adr(8'hB5, a);
      chk("read ack", {7'h0, a}, 8'h00);
      tws_bus_master_inst.stop();
      adr(8'hB4, a);
      chk("own ack", {7'h0, a}, 8'h01);
      chk("stretch", {7'h0, scl_oe}, 8'h01);
      st(ST_OWN_W);
      rd(OFS_CONTROL, d);
      chk("flag", d, 8'hC4);
      $display("test address done");
      wr(OFS_CONTROL, 8'hC4, r);
      tws_bus_master_inst.xfer(8'hA5, a);
      chk("data ack", {7'h0, a}, 8'h01);
      st(ST_DATA_ACK);
      rd(OFS_DATA, d);
      chk("data", d, 8'hA5);
      wr(OFS_CONTROL, 8'h84, r);
      tws_bus_master_inst.xfer(8'h3C, a);
      chk("data nack", {7'h0, a}, 8'h00);
      st(ST_DATA_NACK);
      wr(OFS_CONTROL, 8'hA4, r);
      tws_bus_master_inst.stop();
      chk("start out", n_start[7:0], 8'h01);
      adr(8'hB4, a);
      chk("ack off", {7'h0, a}, 8'h00);
      tws_bus_master_inst.stop();
      $display("test data done");
      wr(OFS_CONTROL, 8'h44, r);
      adr(8'h00, a);
      chk("call ack", {7'h0, a}, 8'h01);
      st(ST_GCALL);
      wr(OFS_CONTROL, 8'hC4, r);
      tws_bus_master_inst.stop();
      // Lost arbitration ahead of an own-address and a call address.
      for (int i = 0; i < 2; i++) begin
         arb_lost <= 1'b1;
         @(posedge aclk);
         arb_lost <= 1'b0;
         adr(i ? 8'h00 : 8'hB4, a);
         st(i ? ST_ARB_GCALL : ST_ARB_OWN_W);
         wr(OFS_CONTROL, 8'hC4, r);
         tws_bus_master_inst.stop();
      end
      wr(OFS_OWN_ADDR, 8'hB4, r);
      adr(8'h00, a);
      chk("call off", {7'h0, a}, 8'h00);
      tws_bus_master_inst.stop();
      $display("test call done");
      // The data register is left unchecked after wake-up.
      sleep_deep <= 1'b1;
      adr(8'hB4, a);
      chk("wake", n_wake[7:0], 8'h01);
      chk("held", {7'h0, scl_oe}, 8'h01);
      wr(OFS_CONTROL, 8'hC4, r);
      sleep_deep <= 1'b0;
      tws_bus_master_inst.stop();
      $display("test sleep done");
      give_verdict();
   end
endmodule
